// *** vhs_consts.vh ***
/*
 * constants for the vocoder host setup controller: apb map, device
 * register addresses, serial frame shape and timing counts.
 * assumes a 100 MHz pclk.
 */
`ifndef VHS_CONSTS_VH
`define VHS_CONSTS_VH

`define VHS_CLK_MHZ 100
`define VHS_SCLK_HALF_NS 100
`define VHS_SCLK_HALF_CYC ((`VHS_SCLK_HALF_NS * `VHS_CLK_MHZ) / 1000)

// apb map of the controller
`define VHS_APB_CMD 8'h00
`define VHS_APB_WDATA 8'h04
`define VHS_APB_RDATA 8'h08
`define VHS_APB_STATUS 8'h0C

// command register fields
`define VHS_CMD_RD_BIT 8

// status register fields
`define VHS_ST_BUSY 0
`define VHS_ST_REFUSED 1
`define VHS_ST_BAD_SPEED 2
`define VHS_ST_SPEED_SET 3
`define VHS_ST_IRQ 4
`define VHS_ST_PUSH_UNACK 5

// device register addresses
`define VHS_DEV_TONE_ATTEN 8'h0A
`define VHS_DEV_CODEC_CTRL 8'h0B
`define VHS_DEV_QUEUE 8'h12
`define VHS_DEV_SPEED 8'h1D
`define VHS_DEV_WATERMARK 8'h1E
`define VHS_DEV_IRQ_MASK 8'h1F
`define VHS_DEV_QUEUE_COUNT 8'h24
`define VHS_DEV_SVC_ACK 8'h2E
`define VHS_DEV_STATUS 8'h40

// device field positions and codes
`define VHS_READY_BIT 4'hF
`define VHS_SVC_DONE_BIT 4'hE
`define VHS_ACK_PUSH_BIT 4'h0
`define VHS_SPEED_SLOW 16'h0005
`define VHS_SPEED_FAST 16'h0006
`define VHS_WM_RSVD_MASK 16'h87FF

// serial frame: 8 address bits then 16 data bits, msb first
`define VHS_FRAME_BITS 5'h18

`endif

// *** vhs_host_ctrl.v ***
/*
 * host-side controller for the vocoder setup registers.  software gives
 * orders over apb; the block runs each as a serial frame, plus any poll frames, on the
 * device control bus and keeps the device's access discipline itself
 * (waits on ready / service-done, checks the push ack, refuses bad
 * speed codes).  assumes the device samples mosi on rising sclk and
 * drives miso to be sampled on rising sclk; miso and irq are async.
 */
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "vhs_consts.vh"

module vhs_host_ctrl (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  output reg cbus_csn,
  output reg cbus_sclk,
  output wire cbus_mosi,
  input wire cbus_miso,
  input wire cbus_irq_n
);

  localparam ST_IDLE = 2'b00;
  localparam ST_LOAD = 2'b01;
  localparam ST_XFER = 2'b10;
  localparam ST_GAP = 2'b11;

  localparam PH_PRE = 2'b00;
  localparam PH_MAIN = 2'b01;
  localparam PH_POST = 2'b10;

  localparam integer HALF_CYC_I = `VHS_SCLK_HALF_CYC;
  localparam [7:0] HALF_CYC = HALF_CYC_I[7:0];

  reg miso_meta;
  reg miso_s;
  reg irq_meta;
  reg irq_n_s;

  reg [1:0] state;
  reg [1:0] phase;
  reg [7:0] divcnt;
  reg [4:0] bitcnt;
  reg [23:0] sh;
  reg [23:0] rx;

  reg [7:0] cur_addr;
  reg cur_rd;
  reg [15:0] wdata;
  reg [15:0] rdata;
  reg [7:0] poll_addr;
  reg [3:0] poll_bit;
  reg post_en;
  reg [3:0] post_bit;

  reg refused;
  reg bad_speed;
  reg speed_set;
  reg speed_pending;
  reg push_unack;

  wire tick = (divcnt == HALF_CYC - 8'h01);
  wire busy = (state != ST_IDLE);
  wire apb_wr = psel & penable & pwrite;
  wire apb_setup = psel & ~penable;
  wire [7:0] cmd_addr = pwdata[7:0];
  wire cmd_rd = pwdata[`VHS_CMD_RD_BIT];
  wire speed_ok = (wdata == `VHS_SPEED_SLOW) || (wdata == `VHS_SPEED_FAST);
  wire addr_ok = (paddr == `VHS_APB_CMD) || (paddr == `VHS_APB_WDATA) ||
                 (paddr == `VHS_APB_RDATA) || (paddr == `VHS_APB_STATUS);
  wire [7:0] x_addr = (phase == PH_MAIN) ? cur_addr : poll_addr;
  wire x_rd = (phase == PH_MAIN) ? cur_rd : 1'b1;
  wire [15:0] x_data = (x_rd) ? 16'h0000 : wdata;

  assign pready = 1'b1;
  assign cbus_mosi = sh[23];

  // async pins pass two flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miso_meta <= 1'b0;
      miso_s <= 1'b0;
      irq_meta <= 1'b1;
      irq_n_s <= 1'b1;
    end else begin
      miso_meta <= cbus_miso;
      miso_s <= miso_meta;
      irq_meta <= cbus_irq_n;
      irq_n_s <= irq_meta;
    end
  end

  // apb read data and error taken in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      pslverr <= ~addr_ok;
      case (paddr)
        `VHS_APB_CMD: prdata <= {23'h000000, cur_rd, cur_addr};
        `VHS_APB_WDATA: prdata <= {16'h0000, wdata};
        `VHS_APB_RDATA: prdata <= {16'h0000, rdata};
        `VHS_APB_STATUS: prdata <= {26'h0000000, push_unack, ~irq_n_s, speed_set,
                                    bad_speed, refused, busy};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // sclk half-period divider, runs only during a job
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divcnt <= 8'h00;
    end else if (!busy || tick) begin
      divcnt <= 8'h00;
    end else begin
      divcnt <= divcnt + 8'h01;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      phase <= PH_MAIN;
      bitcnt <= 5'h00;
      sh <= 24'h000000;
      rx <= 24'h000000;
      cbus_csn <= 1'b1;
      cbus_sclk <= 1'b0;
      cur_addr <= 8'h00;
      cur_rd <= 1'b0;
      wdata <= 16'h0000;
      rdata <= 16'h0000;
      poll_addr <= 8'h00;
      poll_bit <= 4'h0;
      post_en <= 1'b0;
      post_bit <= 4'h0;
      refused <= 1'b0;
      bad_speed <= 1'b0;
      speed_set <= 1'b0;
      speed_pending <= 1'b0;
      push_unack <= 1'b0;
    end else begin
      // software clears refused and bad_speed with write-one; hardware sets below win
      if (apb_wr && paddr == `VHS_APB_STATUS) begin
        if (pwdata[`VHS_ST_REFUSED]) begin
          refused <= 1'b0;
        end
        if (pwdata[`VHS_ST_BAD_SPEED]) begin
          bad_speed <= 1'b0;
        end
      end
      if (apb_wr && paddr == `VHS_APB_WDATA) begin
        if (busy) begin
          refused <= 1'b1;
        end else begin
          wdata <= pwdata[15:0];
        end
      end
      if (apb_wr && paddr == `VHS_APB_CMD) begin
        if (busy) begin
          refused <= 1'b1;
        end else if (!cmd_rd && cmd_addr == `VHS_DEV_SPEED && !speed_ok) begin
          bad_speed <= 1'b1;
        end else begin
          cur_addr <= cmd_addr;
          cur_rd <= cmd_rd;
          state <= ST_LOAD;
          post_en <= 1'b0;
          post_bit <= `VHS_READY_BIT;
          if (!cmd_rd && cmd_addr == `VHS_DEV_WATERMARK) begin
            wdata <= wdata & `VHS_WM_RSVD_MASK;
          end
          if (cmd_rd && cmd_addr == `VHS_DEV_QUEUE_COUNT && push_unack) begin
            phase <= PH_PRE;
            poll_addr <= `VHS_DEV_SVC_ACK;
            poll_bit <= `VHS_ACK_PUSH_BIT;
          end else begin
            phase <= PH_MAIN;
          end
          if (!cmd_rd) begin
            case (cmd_addr)
              `VHS_DEV_QUEUE: begin
                post_en <= 1'b1;
                push_unack <= 1'b0;
              end
              `VHS_DEV_WATERMARK: begin
                post_en <= 1'b1;
              end
              `VHS_DEV_SPEED: begin
                speed_pending <= 1'b1;
                speed_set <= 1'b1;
              end
              `VHS_DEV_TONE_ATTEN: begin
                if (speed_pending) begin
                  post_en <= 1'b1;
                  post_bit <= `VHS_SVC_DONE_BIT;
                  speed_pending <= 1'b0;
                end
              end
              default: begin
              end
            endcase
          end
        end
      end
      case (state)
        ST_LOAD: begin
          sh <= {x_addr, x_data};
          rx <= 24'h000000;
          bitcnt <= 5'h00;
          cbus_csn <= 1'b0;
          cbus_sclk <= 1'b0;
          state <= ST_XFER;
        end
        ST_XFER: begin
          if (tick) begin
            if (!cbus_sclk) begin
              cbus_sclk <= 1'b1;
              rx <= {rx[22:0], miso_s};
              bitcnt <= bitcnt + 5'h01;
            end else begin
              cbus_sclk <= 1'b0;
              sh <= {sh[22:0], 1'b0};
              if (bitcnt == `VHS_FRAME_BITS) begin
                cbus_csn <= 1'b1;
                state <= ST_GAP;
              end
            end
          end
        end
        ST_GAP: begin
          if (tick) begin
            case (phase)
              PH_PRE: begin
                if (rx[poll_bit]) begin
                  push_unack <= 1'b0;
                  phase <= PH_MAIN;
                end
                state <= ST_LOAD;
              end
              PH_MAIN: begin
                if (cur_rd) begin
                  rdata <= rx[15:0];
                end
                if (post_en) begin
                  phase <= PH_POST;
                  poll_addr <= `VHS_DEV_STATUS;
                  poll_bit <= post_bit;
                  state <= ST_LOAD;
                end else begin
                  state <= ST_IDLE;
                end
              end
              PH_POST: begin
                if (rx[poll_bit]) begin
                  if (cur_addr == `VHS_DEV_QUEUE) begin
                    push_unack <= 1'b1;
                  end
                  phase <= PH_MAIN;
                  state <= ST_IDLE;
                end else begin
                  state <= ST_LOAD;
                end
              end
              default: begin
                phase <= PH_MAIN;
                state <= ST_IDLE;
              end
            endcase
          end
        end
        default: begin
        end
      endcase
    end
  end

endmodule

// *** vhs_host_ctrl_unused_guard.v ***
`timescale 1ns/1ps

// *** vhs_dev_model.sv ***
/*
 * behavioural vocoder device on the serial control bus.
 * assumes 24-bit frames, address then data, msb first.
 */
`timescale 1ns/1ps
module vhs_dev_model (
  input wire csn,
  input wire sclk,
  input wire mosi,
  output reg miso,
  output wire irq_n
);
  parameter [15:0] FLUSH = 16'h0001; // arbitrary flush code
  parameter [15:0] START = 16'h0002; // arbitrary sample port start code
  reg [23:0] sh;
  reg [15:0] rv, mask, st, spd, sv, ld, wm_lo, wm_hi;
  reg [10:0] fill;
  reg [7:0] a, la;
  reg [4:0] n, qn, sent;
  reg ack, ok, pend, sp, armed, vdw_en;
  integer lat, viol;
  initial begin
    miso = 0; mask = 16'h8000; st = 0; qn = 0; ack = 0; ok = 0;
    pend = 0; sp = 0; lat = 0; viol = 0; n = 0; la = 0; ld = 0;
    fill = 0; armed = 0; vdw_en = 0; sent = 0;
  end
  assign irq_n = ~|(st & mask);
  function [15:0] rdv(input [7:0] ad);
    case (ad)
      8'h40: rdv = lat ? 16'h0000 : st;
      8'h2E: rdv = {15'h0000, ack};
      8'h24: rdv = {11'h000, qn};
      default: rdv = 16'hA5A5;
    endcase
  endfunction
  always @(posedge sclk or posedge csn)
    if (csn) n <= 0;
    else begin
      sh <= {sh[22:0], mosi};
      n <= n + 5'h01;
    end
  always @(negedge sclk)
    if (n == 5'h08) begin
      miso <= rdv(sh[7:0]) >> 15;
      rv <= rdv(sh[7:0]) << 1;
    end else begin
      miso <= rv[15];
      rv <= {rv[14:0], ~rv[15]};
    end
  always @(posedge csn) begin
    miso <= ~miso;
    a = sh[23:16];
    // a cut frame is not a command
    if (n != 5'h18) begin
    end else if (a == 8'h40) begin
      if (lat > 0) lat = lat - 1;
      else pend = 0;
    end else begin
      la = a;
      ld = sh[15:0];
      if (pend) viol = viol + 1;
      if (a == 8'h2E) ok = ack;
      else if (a == 8'h24) begin
        if (!ok) viol = viol + 1;
      end else begin
        st = 0;
        case (a)
          8'h12: begin qn = qn + 5'h01; ack = 1; ok = 0; st[15] = 1; lat = 1; pend = 1; end
          8'h1E: begin st[15] = 1; lat = 1; pend = 1; armed = !ld[15];
            if (ld[14:11] != 4'h0) viol = viol + 1;
            if (ld[15]) wm_hi = ld; else wm_lo = ld; end
          8'h0A: begin st[14] = 1; if (sp) begin lat = 1; pend = 1; spd = sv; end sp = 0; end
          8'h1D: begin sv = ld; sp = 1; if (ld != 16'h0005 && ld != 16'h0006) viol = viol + 1; end
          8'h1F: mask = ld;
          8'h11: vdw_en = ld[4];
          8'h0B: begin if (ld == FLUSH) qn = 0; if (ld == START) sent = qn; end
          default: ;
        endcase
        if (fill > 11'h320) fill = 11'h320;
        if (fill >= wm_hi[10:0]) armed = 1;
        if (vdw_en && armed && fill < wm_lo[10:0]) begin st[8] = 1; armed = 0; end
      end
    end
  end
endmodule

// *** vhs_host_checker.sv ***
/*
 * port checker for vhs_host_ctrl, bound below.
 * assumes a single pclk domain.
 */
`timescale 1ns/1ps
module vhs_host_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire cbus_csn,
  input wire cbus_sclk,
  input wire cbus_mosi
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire bad = paddr != 8'h00 && paddr != 8'h04 && paddr != 8'h08 && paddr != 8'h0C;
  reg [9:0] lo;
  always @(posedge pclk or negedge presetn)
    if (!presetn) lo <= 10'h000;
    else lo <= cbus_csn ? 10'h000 : lo + 10'h001;
  // cycles since sclk last moved, saturating
  reg sclk_d;
  reg [3:0] hold;
  always @(posedge pclk or negedge presetn)
    if (!presetn) begin
      sclk_d <= 1'b0;
      hold <= 4'hF;
    end else begin
      sclk_d <= cbus_sclk;
      if (cbus_sclk != sclk_d) hold <= 4'h0;
      else if (hold != 4'hF) hold <= hold + 4'h1;
    end
  a_pready_high: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (acc && bad |-> pslverr) else $error("no error");
  a_mapped_ok: assert property (acc && !bad |-> !pslverr) else $error("spurious error");
  a_unmapped_zero: assert property (acc && bad && !pwrite |-> prdata == 32'h0) else $error("data");
  a_status_top: assert property (acc && !pwrite && paddr == 8'h0C |-> prdata[31:6] == 26'h0)
    else $error("status upper bits");
  a_sclk_half: assert property ($changed(cbus_sclk) |-> hold >= 4'h9)
    else $error("sclk half period");
  a_idle_low: assert property (cbus_csn |-> !cbus_sclk) else $error("sclk idle");
  a_mosi_hold: assert property (cbus_sclk && $past(cbus_sclk) |-> $stable(cbus_mosi))
    else $error("mosi moved");
  a_frame_len: assert property ($rose(cbus_csn) |-> lo >= 10'h1DF && lo <= 10'h1E1)
    else $error("frame length");
  a_frame_gap: assert property ($rose(cbus_csn) |=> cbus_csn [*8]) else $error("frame gap");
  cover property ($rose(cbus_csn));
  cover property (acc && bad);
  cover property (acc && pwrite && paddr == 8'h00);
endmodule
bind vhs_host_ctrl vhs_host_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cbus_csn(cbus_csn), .cbus_sclk(cbus_sclk), .cbus_mosi(cbus_mosi));

// *** vhs_tb.sv ***
/*
 * testbench for vhs_host_ctrl with the device model.
 * assumes 100 MHz pclk.
 */
`timescale 1ns/1ps
`include "vhs_consts.vh"
`define CHK(a, b) begin n_checks = n_checks + 1; if ((a) !== (b)) begin \
  err_count = err_count + 1; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
  reg [7:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  reg [47:0] rows [0:8];
  wire [31:0] prdata;
  wire pready, pslverr, csn, sclk, mosi, miso, irq_n;
  integer err_count = 0, n_checks = 0, cyc = 0, i;
  always #5 pclk = ~pclk;
  vhs_host_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cbus_csn(csn), .cbus_sclk(sclk), .cbus_mosi(mosi),
    .cbus_miso(miso), .cbus_irq_n(irq_n));
  vhs_dev_model m (.csn(csn), .sclk(sclk), .mosi(mosi), .miso(miso), .irq_n(irq_n));
  task end_sim;
    begin
      if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count = err_count + 1;
      end_sim;
    end
  end
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata; se = pslverr;
      psel <= 0; penable <= 0;
    end
  endtask
  task idle;
    begin
      rd = 1;
      while (rd[0] !== 1'b0) apb(0, `VHS_APB_STATUS, 0);
    end
  endtask
  task job(input [8:0] c, input [15:0] d);
    begin
      apb(1, `VHS_APB_WDATA, {16'h0000, d});
      apb(1, `VHS_APB_CMD, {23'h0, c});
      idle;
    end
  endtask
  initial begin
    rows[0] = {8'h1D, 16'h0005, 16'h0005, 8'h00};
    rows[1] = {8'h0A, 16'h0010, 16'h0010, 8'h00};
    rows[2] = {8'h1D, 16'h0006, 16'h0006, 8'h00};
    rows[3] = {8'h0A, 16'h0021, 16'h0021, 8'h00};
    rows[4] = {8'h1E, 16'hF9AB, 16'h81AB, 8'h10};
    rows[5] = {8'h12, 16'h1234, 16'h1234, 8'h30};
    rows[6] = {8'h12, 16'h5678, 16'h5678, 8'h30};
    rows[7] = {8'h1F, 16'h4100, 16'h4100, 8'h20};
    rows[8] = {8'h0A, 16'h0000, 16'h0000, 8'h30};
    @(posedge pclk);
    #1;
    `CHK({csn, sclk, prdata}, {2'b10, 32'h0})
    repeat (4) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 9; i = i + 1) begin
      job({1'b0, rows[i][47:40]}, rows[i][39:24]);
      `CHK(m.la, rows[i][47:40])
      `CHK(m.ld, rows[i][23:8])
      `CHK(rd[7:0] & 8'h37, rows[i][7:0])
    end
    `CHK(m.spd, 16'h0006)
    `CHK(m.qn, 5'h02)
    job({1'b1, 8'h24}, 16'h0000);
    apb(0, `VHS_APB_RDATA, 0);
    `CHK(rd[15:0], 16'h0002)
    job(9'h01D, 16'h0007);
    `CHK(rd[2], 1'b1)
    `CHK(m.la, 8'h24)
    apb(1, `VHS_APB_STATUS, 32'h4);
    apb(0, `VHS_APB_STATUS, 0);
    `CHK(rd[2], 1'b0)
    apb(1, `VHS_APB_WDATA, 32'h0101);
    apb(1, `VHS_APB_CMD, 32'h012);
    apb(1, `VHS_APB_CMD, 32'h01F);
    idle;
    `CHK(rd[1], 1'b1)
    `CHK(m.qn, 5'h03)
    `CHK(m.viol, 0)
    apb(0, 8'h10, 0);
    `CHK({se, rd}, {1'b1, 32'h0})
    job(9'h00B, 16'h0002);
    `CHK(m.sent, 5'h03)
    job(9'h00B, 16'h0001);
    `CHK(m.qn, 5'h00)
    job(9'h011, 16'h0010);
    job(9'h01E, 16'h0190);
    `CHK(rd[4], 1'b1)
    m.fill = 11'h3FF;
    job(9'h01F, 16'h0100);
    `CHK(rd[4], 1'b0)
    `CHK(m.fill, 11'h320)
    m.fill = 11'h000;
    job(9'h01F, 16'h0100);
    `CHK(rd[4], 1'b1)
    job(9'h01F, 16'h0100);
    `CHK(rd[4], 1'b0)
    `CHK(m.viol, 0)
    apb(1, `VHS_APB_CMD, 32'h012);
    repeat (100) @(posedge pclk);
    presetn <= 0;
    @(posedge pclk);
    #1;
    `CHK({csn, sclk}, 2'b10)
    @(posedge pclk);
    presetn <= 1;
    apb(0, `VHS_APB_STATUS, 0);
    `CHK(rd[3:0], 4'h0)
    `CHK(rd[5], 1'b0)
    end_sim;
  end
endmodule
